// File: hdl/wdt_cfg.svh
// Constants for the pin-selected watchdog: times in microseconds, reset values.
// Assumes a 20 MHz system clock; tick length is a parameter of the top module.
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

// System clock rate in MHz, gives cycles per microsecond tick
`define WDT_CLK_MHZ      20
// Timing figures, microseconds, as minimum values
`define WDT_T_30US       32'd30
`define WDT_T_200US      32'd200
`define WDT_T_1MS        32'd1000
`define WDT_T_3MS        32'd3000
`define WDT_T_10MS       32'd10000
`define WDT_T_30MS       32'd30000
`define WDT_T_100MS      32'd100000
`define WDT_T_300MS      32'd300000
`define WDT_T_1S         32'd1000000
`define WDT_T_3S         32'd3000000
`define WDT_T_10S        32'd10000000
`define WDT_T_60S        32'd60000000
// Fault pulse width
`define WDT_T_PULSE      `WDT_T_100MS
// Setup delay default, not fixed by the table
`define WDT_T_SETUP      `WDT_T_1MS
// Marker limit meaning wait for the first kick edge
`define WDT_FIRST_EDGE   32'hFFFFFFFF
// Select code that disables monitoring
`define WDT_SEL_OFF      3'h3
// Select value assumed at reset
`define WDT_SEL_RST      3'h0

`endif

// File: hdl/wdt_pkg.sv
// Types shared by the watchdog design.
// Assumes wdt_cfg.svh supplies the numeric constants.
package wdt_pkg;
  // Phases of the supervisor
  typedef enum logic [2:0] {
    Setup,
    Startup,
    FirstEdge,
    Watch,
    Fault,
    Off
  } state_e;

  // Timing variant selected at build time
  typedef logic [1:0] variant_t;
endpackage

// File: hdl/pin_sync.sv
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes inputs are unrelated to clk; output is a clean registered level.
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Raw pin and filtered level
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q;   // Chain stages
  logic [WIDTH-1:0] s1_d, s2_d, s3_d;
  logic [WIDTH-1:0] lvl_q, lvl_d;       // Accepted level

  // A bit counts once stages two and three agree; stage one feeds only stage two
  always_comb begin
    s1_d = pinIn;
    s2_d = s1_q;
    s3_d = s2_q;
    lvl_d = lvl_q;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  // Registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end else begin
      s1_q  <= s1_d;
      s2_q  <= s2_d;
      s3_q  <= s3_d;
      lvl_q <= lvl_d;
    end
  end

  assign levelOut = lvl_q;
endmodule // pin_sync

// File: hdl/pin_select_watchdog_timer.sv
// Pin-selected watchdog supervisor: select pins pick delays, kick pin is watched,
// an active-low fault pulse is sent when kicks stop.
// Assumes kick and select pins are asynchronous; one 20 MHz clock, async reset.
//
// Notes on behaviour
// - Missed kick within timeout raises fault.
// - Variant zero: startup equals timeout per code.
// - Variant one: startup 60 s, timeout per code.
// - Variant two: own pairs, two first-edge codes.
// - Code 011 disables monitoring entirely.
// - Kicks ignored during setup and startup.
// - After startup, timer starts, fault stays off.
// - Valid kick clears timer, restarts from zero.
// - Kicks ignored while fault is asserted.
// - Timer restarts when fault pulse ends.
// - Fault is pulsed, active low, drain selectable.
// - Fault pulse lasts 100 ms then ends.
// - Select change during fault waits for end.
// - Select change to any code but 011 starts fresh setup phase.
// - Without kicks, pulses repeat each timeout.
`timescale 1ns/1ns
`include "wdt_cfg.svh"
module pin_select_watchdog_timer #(
  parameter int             US_CYCLES  = `WDT_CLK_MHZ,  // Clock cycles per microsecond tick
  parameter int             SETUP_US   = `WDT_T_SETUP,  // Setup delay in ticks
  parameter int             PULSE_US   = `WDT_T_PULSE,  // Fault pulse width in ticks
  parameter wdt_pkg::variant_t VARIANT = 2'h0,          // Timing variant 0, 1 or 2
  parameter bit             OPEN_DRAIN = 1'b1           // Open-drain output stage
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Host kick pin
  input  wire logic kickInput,
  // Select pins
  input  wire logic timingSelectBit0,
  input  wire logic timingSelectBit1,
  input  wire logic timingSelectBit2,
  // Fault pin: level and driver enable
  output logic      faultPulseOut_n,
  output logic      faultPulseOe,
  // Status: monitoring of kicks is live
  output logic      monitorActive
);

  ////////////////////////////////////////////////////////////////////////////
  // Time table
  // Returns a limit in ticks for the given code; timeout when wantTimeout.
  function automatic logic [31:0] limitOf(input logic [2:0] sel, input logic wantTimeout);
    logic [31:0] t;
    logic [31:0] s;
    t = `WDT_T_1MS;
    s = `WDT_T_1MS;
    case (VARIANT)
      2'h1: begin
        case (sel)
          3'h0:    t = `WDT_T_1MS;
          3'h1:    t = `WDT_T_3MS;
          3'h2:    t = `WDT_T_10MS;
          3'h4:    t = `WDT_T_100MS;
          3'h5:    t = `WDT_T_300MS;
          3'h6:    t = `WDT_T_3S;
          default: t = `WDT_T_60S;
        endcase
        s = `WDT_T_60S;
      end
      2'h2: begin
        case (sel)
          3'h0:    begin s = `WDT_T_3MS;      t = `WDT_T_3MS;   end
          3'h1:    begin s = `WDT_T_3S;       t = `WDT_T_3S;    end
          3'h2:    begin s = `WDT_T_60S;      t = `WDT_T_1S;    end
          3'h4:    begin s = `WDT_T_200US;    t = `WDT_T_30US;  end
          3'h5:    begin s = `WDT_FIRST_EDGE; t = `WDT_T_1S;    end
          3'h6:    begin s = `WDT_FIRST_EDGE; t = `WDT_T_10S;   end
          default: begin s = `WDT_T_60S;      t = `WDT_T_10S;   end
        endcase
      end
      default: begin
        case (sel)
          3'h0:    t = `WDT_T_1MS;
          3'h1:    t = `WDT_T_10MS;
          3'h2:    t = `WDT_T_30MS;
          3'h4:    t = `WDT_T_100MS;
          3'h5:    t = `WDT_T_1S;
          3'h6:    t = `WDT_T_10S;
          default: t = `WDT_T_60S;
        endcase
        s = t;
      end
    endcase
    return wantTimeout ? t : s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [3:0] pinLevel;   // {sel2, sel1, sel0, kick} after filtering

  pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .pinIn    ({timingSelectBit2, timingSelectBit1, timingSelectBit0, kickInput}),
    .levelOut (pinLevel)
  );

  logic [2:0] selNow;     // Filtered select code
  logic       kickNow;    // Filtered kick level
  assign selNow  = pinLevel[3:1];
  assign kickNow = pinLevel[0];

  ////////////////////////////////////////////////////////////////////////////
  // Supervisor state
  wdt_pkg::state_e state_q, state_d;  // Phase
  logic [31:0] cnt_q, cnt_d;          // Elapsed ticks in phase
  logic [31:0] pre_q, pre_d;          // Cycle prescaler for the tick
  logic [2:0]  sel_q, sel_d;          // Code in force
  logic        kickPrev_q, kickPrev_d;
  logic        fault_n_q, fault_n_d;
  logic        oe_q, oe_d;
  logic        act_q, act_d;

  logic tick;        // One microsecond has passed
  logic kickEdge;    // Either edge of the kick pin
  logic selChange;   // Pins differ from code in force
  assign tick      = (pre_q == 32'(US_CYCLES - 1));
  assign kickEdge  = (kickNow != kickPrev_q);
  assign selChange = (selNow != sel_q);

  // Next-state logic. Counts compare with >= so every delay is a minimum.
  always_comb begin
    state_d    = state_q;
    sel_d      = sel_q;
    kickPrev_d = kickNow;
    fault_n_d  = fault_n_q;
    pre_d      = tick ? 32'h0 : pre_q + 32'h1;
    cnt_d      = tick ? cnt_q + 32'h1 : cnt_q;
    if (selChange && state_q != wdt_pkg::Fault) begin
      // New code, fresh setup phase (Off for code 011), no power cycle needed
      sel_d   = selNow;
      state_d = (selNow == `WDT_SEL_OFF) ? wdt_pkg::Off : wdt_pkg::Setup;
      cnt_d   = 32'h0;
      pre_d   = 32'h0;
    end else begin
      case (state_q)
        wdt_pkg::Setup: begin
          // Kicks ignored here
          if (cnt_q >= 32'(SETUP_US)) begin
            state_d = (limitOf(sel_q, 1'b0) == `WDT_FIRST_EDGE) ?
                      wdt_pkg::FirstEdge : wdt_pkg::Startup;
            cnt_d   = 32'h0;
            pre_d   = 32'h0;
          end
        end
        wdt_pkg::Startup: begin
          if (cnt_q >= limitOf(sel_q, 1'b0)) begin
            state_d = wdt_pkg::Watch;
            cnt_d   = 32'h0;
            pre_d   = 32'h0;
          end
        end
        wdt_pkg::FirstEdge: begin
          // Counter parked; waits without limit for the host
          cnt_d = 32'h0;
          if (kickEdge) begin
            state_d = wdt_pkg::Watch;
            pre_d   = 32'h0;
          end
        end
        wdt_pkg::Watch: begin
          if (kickEdge) begin
            cnt_d = 32'h0;
            pre_d = 32'h0;
          end else if (cnt_q >= limitOf(sel_q, 1'b1)) begin
            state_d   = wdt_pkg::Fault;
            fault_n_d = 1'b0;
            cnt_d     = 32'h0;
            pre_d     = 32'h0;
          end
        end
        wdt_pkg::Fault: begin
          // Kicks are ignored and select changes wait for the pulse to end.
          if (cnt_q >= 32'(PULSE_US)) begin
            fault_n_d = 1'b1;
            cnt_d     = 32'h0;
            pre_d     = 32'h0;
            if (selChange) begin
              sel_d   = selNow;
              state_d = (selNow == `WDT_SEL_OFF) ? wdt_pkg::Off : wdt_pkg::Setup;
            end else begin
              state_d = wdt_pkg::Watch;
            end
          end
        end
        wdt_pkg::Off: begin
          // Monitoring stopped; only a select change leaves
          cnt_d = 32'h0;
          pre_d = 32'h0;
        end
        default: begin
          state_d = wdt_pkg::Setup;
          cnt_d   = 32'h0;
          pre_d   = 32'h0;
        end
      endcase
    end
    // Open drain drives only the low level; push-pull always drives.
    oe_d  = OPEN_DRAIN ? !fault_n_d : 1'b1;
    act_d = (state_d == wdt_pkg::Watch);
  end

  // Registers only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= wdt_pkg::Setup;
      cnt_q      <= 32'h0;
      pre_q      <= 32'h0;
      sel_q      <= `WDT_SEL_RST;
      kickPrev_q <= 1'b0;
      fault_n_q  <= 1'b1;
      oe_q       <= !OPEN_DRAIN;
      act_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      pre_q      <= pre_d;
      sel_q      <= sel_d;
      kickPrev_q <= kickPrev_d;
      fault_n_q  <= fault_n_d;
      oe_q       <= oe_d;
      act_q      <= act_d;
    end
  end

  assign faultPulseOut_n = fault_n_q;
  assign faultPulseOe    = oe_q;
  assign monitorActive   = act_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_off_silent: assert property (state_q == wdt_pkg::Off |-> fault_n_q)
    else $error("fault asserted while disabled");
  a_early_quiet: assert property (
    state_q inside {wdt_pkg::Setup, wdt_pkg::Startup, wdt_pkg::FirstEdge} |-> fault_n_q)
    else $error("fault during setup or startup");
  a_startup_end: assert property (
    state_q == wdt_pkg::Startup && !selChange && cnt_q >= limitOf(sel_q, 1'b0)
    |=> state_q == wdt_pkg::Watch && cnt_q == 32'h0 && fault_n_q)
    else $error("watch did not start after startup");
  a_kick_clears: assert property (
    state_q == wdt_pkg::Watch && kickEdge && !selChange |=> cnt_q == 32'h0 && fault_n_q)
    else $error("kick did not clear timer");
  a_timeout_fault: assert property (
    state_q == wdt_pkg::Watch && !kickEdge && !selChange && cnt_q >= limitOf(sel_q, 1'b1)
    |=> !fault_n_q && state_q == wdt_pkg::Fault)
    else $error("timeout without fault");
  a_fault_holds: assert property (
    state_q == wdt_pkg::Fault && cnt_q < 32'(PULSE_US) |=> state_q == wdt_pkg::Fault)
    else $error("fault pulse cut short");
  a_pulse_ends: assert property (
    state_q == wdt_pkg::Fault && cnt_q >= 32'(PULSE_US) |=> fault_n_q ##0 cnt_q == 32'h0)
    else $error("fault pulse did not end");
  a_sel_kept: assert property (
    state_q == wdt_pkg::Fault |=> $stable(sel_q) || state_q != wdt_pkg::Fault)
    else $error("code changed during fault");
  a_sel_restart: assert property (
    state_q != wdt_pkg::Fault && selChange
    |=> state_q inside {wdt_pkg::Setup, wdt_pkg::Off} && cnt_q == 32'h0)
    else $error("select change did not restart");
  a_pin_level: assert property (
    OPEN_DRAIN |-> (faultPulseOe == !faultPulseOut_n))
    else $error("open drain enable mismatch");

  c_fault_seen:  cover property ($fell(fault_n_q));
  c_kick_watch:  cover property (state_q == wdt_pkg::Watch && kickEdge);
  c_sel_in_flt:  cover property (state_q == wdt_pkg::Fault && selChange);
  c_disabled:    cover property (state_q == wdt_pkg::Off);

endmodule // pin_select_watchdog_timer

// File: tb/host_kicker.sv
// Host model for the watchdog: toggles the kick pin at a fixed spacing while told to run.
// Assumes one clock shared with the bench; drives only at the falling edge.
`timescale 1ns/1ns
module host_kicker #(
  parameter int GAP = 10 // Clocks between kick toggles, well under one timeout
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control from the bench
  input  wire logic kickRun,
  // Kick pin
  output logic      kickLevel
);
  int gapCnt; // Clocks since the last toggle

  ////////////////////////////////////////////////////////////////////////////////
  // Toggle on the falling edge so the pin is never moving at the sampling edge
  always @(negedge clk or posedge rst) begin
    if (rst) begin
      kickLevel <= 1'b0;
      gapCnt    <= 0;
    end else if (kickRun) begin
      // Spacing is far above the 4-clock filter, so both edges are seen
      if (gapCnt == GAP - 1) begin
        kickLevel <= ~kickLevel;
        gapCnt    <= 0;
      end else begin
        gapCnt <= gapCnt + 1;
      end
    end
    // Select pins are never tied to the fault pin here, all-zero codes included
  end
endmodule // host_kicker

// File: tb/pin_select_watchdog_timer_tb.sv
// Self-checking bench for the pin-selected watchdog, timing variant two, shrunk ticks.
// Assumes one tick per clock; host_kicker stands in for the host processor.
`timescale 1ns/1ns
module pin_select_watchdog_timer_tb;
  localparam int SETUP = 5;   // Setup delay in ticks
  localparam int PULSE = 5;   // Fault pulse width in ticks
  localparam int TO    = 30;  // Timeout for code 100
  localparam int ST    = 200; // Startup for code 100
  localparam int FIRST = SETUP + ST + TO; // Earliest first fault after a select change
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       kickRun = 1'b0;
  logic [2:0] sel = 3'h4;
  logic       kick, faultN, faultOe, monOn;
  int         n_fail = 0;
  int         samples_checked = 0;
  int         falls, t;
  // Rows: select code, host kicking, fault expected, monitor level expected
  logic [2:0] rSel [3] = '{3'h4, 3'h3, 3'h4};
  logic       rRun [3] = '{1'b1, 1'b0, 1'b0};
  logic       rFlt [3] = '{1'b0, 1'b0, 1'b1};
  logic       rMon [3] = '{1'b1, 1'b0, 1'b0};

  always #25 clk = ~clk;

  host_kicker #(.GAP(10)) host (.clk(clk), .rst(rst), .kickRun(kickRun), .kickLevel(kick));

  pin_select_watchdog_timer #(.US_CYCLES(1), .SETUP_US(SETUP), .PULSE_US(PULSE),
    .VARIANT(2'h2), .OPEN_DRAIN(1'b1)) dut (
    .clk(clk), .rst(rst), .kickInput(kick), .timingSelectBit0(sel[0]),
    .timingSelectBit1(sel[1]), .timingSelectBit2(sel[2]), .faultPulseOut_n(faultN),
    .faultPulseOe(faultOe), .monitorActive(monOn));

  ////////////////////////////////////////////////////////////////////////////////
  // Report and comparison tasks
  task automatic end_sim();
    $display("checked %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk_bit(string what, logic exp, logic got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask

  task automatic chk_range(string what, int lo, int hi, int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, got);
    end
  endtask

  // Count fault falls over a fixed observation window
  task automatic watch(int n, output int nf);
    logic prev;
    nf = 0;
    prev = faultN;
    repeat (n) begin
      @(negedge clk);
      if (prev === 1'b1 && faultN === 1'b0) nf++;
      prev = faultN;
    end
  endtask

  // Bounded wait for the fault pin to reach a level; gives the clocks taken
  task automatic wait_lvl(logic lvl, int lim, output int c);
    c = 0;
    while (faultN !== lvl) begin
      @(negedge clk);
      c++;
      if (c > lim) begin
        n_fail++;
        $display("unexpected fault level wait: expected %b, seen %b", lvl, faultN);
        end_sim();
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    // Reset values held while reset is high
    repeat (2) @(negedge clk);
    chk_bit("fault level in reset", 1'b1, faultN);
    chk_bit("fault enable in reset", 1'b0, faultOe);
    chk_bit("monitor in reset", 1'b0, monOn);
    rst = 1'b0;
    $display("test reset done");

    // Ordinary cases from the table
    for (int i = 0; i < 3; i++) begin
      sel = rSel[i];
      kickRun <= rRun[i];
      watch(300, falls);
      chk_bit("fault seen", rFlt[i], falls > 0);
      if (i < 2) chk_bit("monitor live", rMon[i], monOn);
      $display("test row %0d done", i);
    end

    // Second reset in mid-run, then timing of unkicked pulses; kicks in setup and startup only
    @(negedge clk);
    rst = 1'b1;
    sel = 3'h4;
    kickRun <= 1'b1;
    @(negedge clk);
    rst = 1'b0;
    repeat (150) @(negedge clk);
    kickRun <= 1'b0;
    wait_lvl(1'b0, FIRST + 100, t);
    chk_range("first fault time", FIRST - 150, FIRST + 45 - 150, t);
    chk_bit("fault enable while low", 1'b1, faultOe);
    chk_bit("monitor while fault", 1'b0, monOn);
    wait_lvl(1'b1, PULSE + 40, t);
    chk_range("pulse width", PULSE, PULSE + 25, t + 1);
    chk_bit("fault enable released", 1'b0, faultOe);
    wait_lvl(1'b0, TO + 40, t);
    chk_range("repeat gap", TO, TO + 25, t + 1);
    $display("test pulse timing done");

    // Select change during the pulse waits for its end, then monitoring stops
    sel = 3'h3;
    kickRun <= 1'b1;
    wait_lvl(1'b1, PULSE + 40, t);
    chk_range("pulse width after select change", PULSE, PULSE + 25, t + 1);
    kickRun <= 1'b0;
    watch(400, falls);
    chk_bit("fault after disable", 1'b0, falls > 0);
    $display("test select during fault done");

    // First-edge code: no timing at all until the host kicks once
    sel = 3'h5;
    watch(300, falls);
    chk_bit("fault before first kick", 1'b0, falls > 0);
    chk_bit("monitor before first kick", 1'b0, monOn);
    kickRun <= 1'b1;
    repeat (40) @(negedge clk);
    chk_bit("monitor after first kick", 1'b1, monOn);
    $display("test first edge done");

    // Code 000 with no kicks: setup, 3 ms startup, 3 ms timeout, each a minimum
    kickRun <= 1'b0;
    sel = 3'h0;
    wait_lvl(1'b0, SETUP + 6100, t);
    chk_range("code 000 first fault", SETUP + 6000, SETUP + 6045, t);
    $display("test code 000 done");
    end_sim();
  end
endmodule // pin_select_watchdog_timer_tb
